// *** src/twbme_top.sv ***
// Chosen here: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/100ps
// How it works
// - Set flag stalls bus, as master or addressed slave, until software clears
// - Hardware never clears the interrupt flag
// - Writing one clears flag; engine resumes
// - Start request waits for free bus, 08
// - Address with write acked: 18, 20, 38
// - Data write with flag low sets collision
// - Stop request in master sends STOP
// - Repeated start reports 10, keeps bus
// - Address with read acked: 40, 48, 38
// - Received byte readable while flag set
// - Own address upper bits, bit 0 general call
// - Own address or general call, write: slave
// - Lost arbitration then addressed: 68 or 78
// - Acknowledge off: not-acknowledge after next byte
// - Acknowledge off ignores own address
// - Sleeping: recognise address, wake, hold SCL
// - Data not updated by address during sleep
// - Read high, write low, ack low, nack high
// - Status reads F8 when nothing pending
// - Misplaced START or STOP: bus error 00
module twbme_top #(
	parameter int HALF_CYCLES = twbme_pkg::SCL_HALF_CYCLES
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// AHB-Lite register port
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// Two-wire bus, open drain
	input wire logic scl_i,
	output logic scl_o,
	output logic scl_oe_n,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_n,
	// Sleep handshake
	input wire logic clocks_stopped,
	output logic wake_request
);
	twbme_reg_if rif ();
	twbme_line_if line ();

	twbme_ahb_slave u_ahb (
		.clk(clk),
		.rst(rst),
		.hsel(hsel),
		.haddr(haddr),
		.htrans(htrans),
		.hwrite(hwrite),
		.hsize(hsize),
		.hwdata(hwdata),
		.hready(hready),
		.hreadyout(hreadyout),
		.hresp(hresp),
		.hrdata(hrdata),
		.rif(rif)
	);

	twbme_line_sync u_sync (
		.clk(clk),
		.rst(rst),
		.scl_i(scl_i),
		.sda_i(sda_i),
		.line(line)
	);

	// Half-period tick for master timing
	logic [twbme_pkg::TICK_W-1:0] tcnt, next_tcnt;
	logic tick;
	assign tick = (tcnt == twbme_pkg::TICK_W'(HALF_CYCLES - 1));
	always_comb begin
		next_tcnt = tick ? '0 : tcnt + 1'b1;
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			tcnt <= '0;
		end else begin
			tcnt <= next_tcnt;
		end
	end

	// Control, data and engine state
	logic flag, next_flag;
	logic ack_en, next_ack_en;
	logic start_req, next_start_req;
	logic stop_req, next_stop_req;
	logic wcol, next_wcol;
	logic enable, next_enable;
	logic int_en, next_int_en;
	logic [7:0] own_addr, next_own_addr;
	logic [7:0] data, next_data;
	logic [7:0] status, next_status;
	twbme_pkg::twbme_state_t state, next_state;
	logic [1:0] phase, next_phase;
	logic [3:0] bitcnt, next_bitcnt;
	logic [7:0] shift, next_shift;
	logic is_master, next_is_master;
	logic m_rx, next_m_rx;
	logic addr_byte, next_addr_byte;
	logic arb_lost, next_arb_lost;
	logic gc_hit, next_gc_hit;
	logic addressed, next_addressed;
	logic bus_busy, next_bus_busy;
	logic next_scl_oe_n, next_sda_oe_n, next_wake;
	logic [7:0] rx;
	logic own_match, gc_match, set_flag, misplaced;

	assign rx = {shift[6:0], line.sda};
	assign own_match = shift[7:1] == own_addr[7:1];
	assign gc_match = shift[7:1] == 7'h00 && own_addr[0];

	// Register read mux; reserved bits read zero
	always_comb begin
		unique case (rif.rd_idx)
			twbme_pkg::IDX_STATUS: rif.rdata = flag ? status
				: twbme_pkg::ST_NONE;
			twbme_pkg::IDX_ADDR: rif.rdata = own_addr;
			twbme_pkg::IDX_DATA: rif.rdata = data;
			twbme_pkg::IDX_CTRL: rif.rdata = {flag, ack_en, start_req,
				stop_req, wcol, enable, 1'b0, int_en};
			default: rif.rdata = 8'h00;
		endcase
	end

	// Software writes, then the bus engine; engine sets win
	always_comb begin
		next_flag = flag;
		next_ack_en = ack_en;
		next_start_req = start_req;
		next_stop_req = stop_req;
		next_wcol = wcol;
		next_enable = enable;
		next_int_en = int_en;
		next_own_addr = own_addr;
		next_data = data;
		next_status = status;
		next_state = state;
		next_phase = phase;
		next_bitcnt = bitcnt;
		next_shift = shift;
		next_is_master = is_master;
		next_m_rx = m_rx;
		next_addr_byte = addr_byte;
		next_arb_lost = arb_lost;
		next_gc_hit = gc_hit;
		next_addressed = addressed;
		next_bus_busy = bus_busy;
		next_scl_oe_n = scl_oe_n;
		next_sda_oe_n = sda_oe_n;
		next_wake = wake_request & clocks_stopped;
		set_flag = 1'b0;
		misplaced = line.start_seen | line.stop_seen;
		if (rif.wr) begin
			unique case (rif.wr_idx)
				twbme_pkg::IDX_CTRL: begin
					next_ack_en = rif.wdata[twbme_pkg::CTRL_ACK];
					next_start_req = rif.wdata[twbme_pkg::CTRL_START];
					next_stop_req = rif.wdata[twbme_pkg::CTRL_STOP];
					next_enable = rif.wdata[twbme_pkg::CTRL_EN];
					next_int_en = rif.wdata[twbme_pkg::CTRL_IE];
					if (rif.wdata[twbme_pkg::CTRL_FLAG]) begin
						next_flag = 1'b0;
					end
				end
				twbme_pkg::IDX_ADDR: next_own_addr = rif.wdata;
				twbme_pkg::IDX_DATA: begin
					if (flag) begin
						next_data = rif.wdata;
						next_wcol = 1'b0;
					end else begin
						next_wcol = 1'b1;
					end
				end
				default: ;
			endcase
		end
		if (line.start_seen) begin
			next_bus_busy = 1'b1;
		end
		if (line.stop_seen) begin
			next_bus_busy = 1'b0;
		end
		if (!enable) begin
			// Disabled: lines released, inputs ignored except for bus busy tracking
			next_state = twbme_pkg::ST_IDLE;
			next_scl_oe_n = 1'b1;
			next_sda_oe_n = 1'b1;
			next_is_master = 1'b0;
			next_addressed = 1'b0;
		end else begin
			unique case (state)
				twbme_pkg::ST_IDLE: begin
					next_scl_oe_n = 1'b1;
					next_sda_oe_n = 1'b1;
					next_is_master = 1'b0;
					next_arb_lost = 1'b0;
					if (line.start_seen) begin
						next_state = twbme_pkg::ST_SBIT;
						next_bitcnt = 4'h0;
						next_addr_byte = 1'b1;
						next_addressed = 1'b0;
					end else if (start_req && !flag && !bus_busy) begin
						next_state = twbme_pkg::ST_MSTART;
						next_phase = 2'h0;
					end
				end
				twbme_pkg::ST_MSTART: begin
					// Release SDA, release SCL, drop SDA, drop SCL
					if (tick) begin
						unique case (phase)
							2'h0: begin
								next_sda_oe_n = 1'b1;
								next_phase = 2'h1;
							end
							2'h1: begin
								next_scl_oe_n = 1'b1;
								next_phase = 2'h2;
							end
							2'h2: begin
								if (line.scl && line.sda) begin
									next_sda_oe_n = 1'b0;
									next_phase = 2'h3;
								end
							end
							2'h3: begin
								next_scl_oe_n = 1'b0;
								next_status = is_master
									? twbme_pkg::ST_RESTART
									: twbme_pkg::ST_START;
								next_is_master = 1'b1;
								set_flag = 1'b1;
								next_state = twbme_pkg::ST_HOLD;
							end
						endcase
					end
				end
				twbme_pkg::ST_MBIT, twbme_pkg::ST_MACK: begin
					if (misplaced) begin
						next_status = twbme_pkg::ST_BUS_ERR;
						set_flag = 1'b1;
						next_is_master = 1'b0;
						next_scl_oe_n = 1'b1;
						next_sda_oe_n = 1'b1;
						next_state = twbme_pkg::ST_HOLD;
					end else if (tick) begin
						unique case (phase)
							2'h0: begin
								if (state == twbme_pkg::ST_MACK) begin
									// Ack driven low, nack left high
									next_sda_oe_n = (m_rx && !addr_byte)
										? !ack_en : 1'b1;
								end else begin
									next_sda_oe_n = (m_rx && !addr_byte)
										? 1'b1 : shift[7];
								end
								next_phase = 2'h1;
							end
							2'h1: begin
								next_scl_oe_n = 1'b1;
								next_phase = 2'h2;
							end
							default: begin
								if (line.scl && state == twbme_pkg::ST_MBIT)
									begin
									next_shift = rx;
									next_bitcnt = bitcnt + 4'h1;
									next_phase = 2'h0;
									next_scl_oe_n = 1'b0;
									if ((!m_rx || addr_byte) && shift[7]
										&& !line.sda) begin
										// Lost: in the address byte go on listening as slave, in a data byte report 38
										next_is_master = 1'b0;
										next_arb_lost = 1'b1;
										next_scl_oe_n = 1'b1;
										next_sda_oe_n = 1'b1;
										if (addr_byte) begin
											next_state = twbme_pkg::ST_SBIT;
										end else begin
											next_status =
												twbme_pkg::ST_ARB_LOST;
											set_flag = 1'b1;
											next_state = twbme_pkg::ST_HOLD;
										end
									end else if (bitcnt == 4'h7) begin
										next_state = twbme_pkg::ST_MACK;
									end
								end else if (line.scl) begin
									next_scl_oe_n = 1'b0;
									set_flag = 1'b1;
									next_state = twbme_pkg::ST_HOLD;
									if (m_rx && !addr_byte) begin
										next_data = shift;
										next_status = line.sda
											? twbme_pkg::ST_RX_NACK
											: twbme_pkg::ST_RX_ACK;
									end else if (m_rx) begin
										next_status = line.sda
											? twbme_pkg::ST_AR_NACK
											: twbme_pkg::ST_AR_ACK;
									end else if (addr_byte) begin
										next_status = line.sda
											? twbme_pkg::ST_AW_NACK
											: twbme_pkg::ST_AW_ACK;
									end else begin
										next_status = line.sda
											? twbme_pkg::ST_TX_NACK
											: twbme_pkg::ST_TX_ACK;
									end
								end
							end
						endcase
					end
				end
				twbme_pkg::ST_MSTOP: begin
					// SDA low, release SCL, release SDA
					if (tick) begin
						unique case (phase)
							2'h0: begin
								next_sda_oe_n = 1'b0;
								next_phase = 2'h1;
							end
							2'h1: begin
								next_scl_oe_n = 1'b1;
								next_phase = 2'h2;
							end
							2'h2: begin
								if (line.scl) begin
									next_sda_oe_n = 1'b1;
									next_phase = 2'h3;
								end
							end
							2'h3: begin
								next_stop_req = 1'b0;
								next_is_master = 1'b0;
								next_state = twbme_pkg::ST_IDLE;
							end
						endcase
					end
				end
				twbme_pkg::ST_SBIT: begin
					if (misplaced && bitcnt != 4'h0) begin
						next_status = twbme_pkg::ST_BUS_ERR;
						set_flag = 1'b1;
						next_addressed = 1'b0;
						next_scl_oe_n = 1'b1;
						next_sda_oe_n = 1'b1;
						next_state = twbme_pkg::ST_HOLD;
					end else if (line.start_seen) begin
						next_addr_byte = 1'b1;
						next_addressed = 1'b0;
					end else if (line.stop_seen) begin
						if (addressed) begin
							next_status = twbme_pkg::ST_SR_STOP;
							set_flag = 1'b1;
							next_addressed = 1'b0;
							next_state = twbme_pkg::ST_HOLD;
						end else begin
							next_state = twbme_pkg::ST_IDLE;
						end
					end else if (line.scl_rise && bitcnt != 4'h8) begin
						next_shift = rx;
						next_bitcnt = bitcnt + 4'h1;
					end else if (line.scl_fall && bitcnt == 4'h8) begin
						if (addr_byte) begin
							if (!clocks_stopped) begin
								next_data = shift;
							end
							if (ack_en && !shift[0]
								&& (own_match || gc_match)) begin
								next_sda_oe_n = 1'b0;
								next_addressed = 1'b1;
								next_gc_hit = !own_match;
								next_wake = clocks_stopped;
								next_state = twbme_pkg::ST_SACK;
								if (own_match) begin
									next_status = arb_lost
										? twbme_pkg::ST_SR_OWN_ARB
										: twbme_pkg::ST_SR_OWN;
								end else begin
									next_status = arb_lost
										? twbme_pkg::ST_SR_GC_ARB
										: twbme_pkg::ST_SR_GC;
								end
							end else if (arb_lost) begin
								next_status = twbme_pkg::ST_ARB_LOST;
								set_flag = 1'b1;
								next_state = twbme_pkg::ST_HOLD;
							end else begin
								next_state = twbme_pkg::ST_IDLE;
							end
						end else begin
							next_data = shift;
							next_sda_oe_n = !ack_en;
							next_addressed = ack_en;
							next_state = twbme_pkg::ST_SACK;
							if (gc_hit) begin
								next_status = ack_en
									? twbme_pkg::ST_SR_GCD_ACK
									: twbme_pkg::ST_SR_GCD_NACK;
							end else begin
								next_status = ack_en
									? twbme_pkg::ST_SR_DATA_ACK
									: twbme_pkg::ST_SR_DATA_NACK;
							end
						end
					end
				end
				twbme_pkg::ST_SACK: begin
					if (misplaced) begin
						next_status = twbme_pkg::ST_BUS_ERR;
						set_flag = 1'b1;
						next_addressed = 1'b0;
						next_scl_oe_n = 1'b1;
						next_sda_oe_n = 1'b1;
						next_state = twbme_pkg::ST_HOLD;
					end else if (line.scl_fall) begin
						// Stretch the clock while software works, if still addressed
						next_sda_oe_n = 1'b1;
						next_scl_oe_n = !addressed;
						set_flag = 1'b1;
						next_state = twbme_pkg::ST_HOLD;
					end
				end
				twbme_pkg::ST_HOLD: begin
					if (!flag) begin
						next_phase = 2'h0;
						next_bitcnt = 4'h0;
						if (stop_req && is_master) begin
							next_state = twbme_pkg::ST_MSTOP;
						end else if (stop_req) begin
							// Error recovery: quiet release, no STOP
							next_stop_req = 1'b0;
							next_addressed = 1'b0;
							next_scl_oe_n = 1'b1;
							next_sda_oe_n = 1'b1;
							next_state = twbme_pkg::ST_IDLE;
						end else if (is_master && start_req) begin
							next_state = twbme_pkg::ST_MSTART;
						end else if (is_master) begin
							next_shift = data;
							next_addr_byte = status == twbme_pkg::ST_START
								|| status == twbme_pkg::ST_RESTART;
							if (status == twbme_pkg::ST_START
								|| status == twbme_pkg::ST_RESTART) begin
								next_m_rx = data[0];
							end
							next_state = twbme_pkg::ST_MBIT;
						end else if (addressed) begin
							next_scl_oe_n = 1'b1;
							next_addr_byte = 1'b0;
							next_state = twbme_pkg::ST_SBIT;
						end else begin
							next_scl_oe_n = 1'b1;
							next_sda_oe_n = 1'b1;
							next_state = twbme_pkg::ST_IDLE;
						end
					end
				end
				default: next_state = twbme_pkg::ST_IDLE;
			endcase
		end
		if (set_flag) begin
			next_flag = 1'b1;
		end
	end

	// Register every piece of state except the tick counter, which has its own block above
	always_ff @(posedge clk) begin
		if (rst) begin
			flag <= 1'b0;
			ack_en <= 1'b0;
			start_req <= 1'b0;
			stop_req <= 1'b0;
			wcol <= 1'b0;
			enable <= 1'b0;
			int_en <= 1'b0;
			own_addr <= twbme_pkg::RST_ADDR;
			data <= twbme_pkg::RST_DATA;
			status <= twbme_pkg::ST_NONE;
			state <= twbme_pkg::ST_IDLE;
			phase <= 2'h0;
			bitcnt <= 4'h0;
			shift <= 8'h00;
			is_master <= 1'b0;
			m_rx <= 1'b0;
			addr_byte <= 1'b0;
			arb_lost <= 1'b0;
			gc_hit <= 1'b0;
			addressed <= 1'b0;
			bus_busy <= 1'b0;
			scl_oe_n <= 1'b1;
			sda_oe_n <= 1'b1;
			wake_request <= 1'b0;
			scl_o <= 1'b0;
			sda_o <= 1'b0;
		end else begin
			flag <= next_flag;
			ack_en <= next_ack_en;
			start_req <= next_start_req;
			stop_req <= next_stop_req;
			wcol <= next_wcol;
			enable <= next_enable;
			int_en <= next_int_en;
			own_addr <= next_own_addr;
			data <= next_data;
			status <= next_status;
			state <= next_state;
			phase <= next_phase;
			bitcnt <= next_bitcnt;
			shift <= next_shift;
			is_master <= next_is_master;
			m_rx <= next_m_rx;
			addr_byte <= next_addr_byte;
			arb_lost <= next_arb_lost;
			gc_hit <= next_gc_hit;
			addressed <= next_addressed;
			bus_busy <= next_bus_busy;
			scl_oe_n <= next_scl_oe_n;
			sda_oe_n <= next_sda_oe_n;
			wake_request <= next_wake;
			scl_o <= 1'b0;
			sda_o <= 1'b0;
		end
	end
endmodule // twbme_top

// *** shared/twbme_pkg.sv ***
package twbme_pkg;
	// Register indices; byte address is four times the index
	localparam logic [2:0] IDX_STATUS = 3'h1;
	localparam logic [2:0] IDX_ADDR = 3'h2;
	localparam logic [2:0] IDX_DATA = 3'h3;
	localparam logic [2:0] IDX_CTRL = 3'h4;
	localparam int IDX_LSB = 2;
	localparam int IDX_MSB = 4;

	// Control field positions
	localparam int CTRL_FLAG = 7;
	localparam int CTRL_ACK = 6;
	localparam int CTRL_START = 5;
	localparam int CTRL_STOP = 4;
	localparam int CTRL_WCOL = 3;
	localparam int CTRL_EN = 2;
	localparam int CTRL_IE = 0;

	// Values after reset
	localparam logic [7:0] RST_ADDR = 8'hfe;
	localparam logic [7:0] RST_DATA = 8'hff;

	// Status codes
	localparam logic [7:0] ST_NONE = 8'hf8;
	localparam logic [7:0] ST_BUS_ERR = 8'h00;
	localparam logic [7:0] ST_START = 8'h08;
	localparam logic [7:0] ST_RESTART = 8'h10;
	localparam logic [7:0] ST_AW_ACK = 8'h18;
	localparam logic [7:0] ST_AW_NACK = 8'h20;
	localparam logic [7:0] ST_TX_ACK = 8'h28;
	localparam logic [7:0] ST_TX_NACK = 8'h30;
	localparam logic [7:0] ST_ARB_LOST = 8'h38;
	localparam logic [7:0] ST_AR_ACK = 8'h40;
	localparam logic [7:0] ST_AR_NACK = 8'h48;
	localparam logic [7:0] ST_RX_ACK = 8'h50;
	localparam logic [7:0] ST_RX_NACK = 8'h58;
	localparam logic [7:0] ST_SR_OWN = 8'h60;
	localparam logic [7:0] ST_SR_OWN_ARB = 8'h68;
	localparam logic [7:0] ST_SR_GC = 8'h70;
	localparam logic [7:0] ST_SR_GC_ARB = 8'h78;
	localparam logic [7:0] ST_SR_DATA_ACK = 8'h80;
	localparam logic [7:0] ST_SR_DATA_NACK = 8'h88;
	localparam logic [7:0] ST_SR_GCD_ACK = 8'h90;
	localparam logic [7:0] ST_SR_GCD_NACK = 8'h98;
	localparam logic [7:0] ST_SR_STOP = 8'ha0;

	// Master bus timing
	localparam int CLK_PERIOD_NS = 20;
	localparam int SCL_HALF_NS = 5000;
	localparam int SCL_HALF_CYCLES =
		(SCL_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int TICK_W = 12;

	// Engine states, Gray coded in the order listed
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_MSTART = 3'b001,
		ST_MBIT = 3'b011,
		ST_MACK = 3'b010,
		ST_MSTOP = 3'b110,
		ST_SBIT = 3'b111,
		ST_SACK = 3'b101,
		ST_HOLD = 3'b100
	} twbme_state_t;
endpackage

// *** shared/twbme_reg_if.sv ***
`timescale 1ns/100ps
interface twbme_reg_if;
	logic wr;
	logic [2:0] wr_idx;
	logic [7:0] wdata;
	logic [2:0] rd_idx;
	logic [7:0] rdata;
	modport bus (output wr, output wr_idx, output wdata, output rd_idx,
		input rdata);
	modport regs (input wr, input wr_idx, input wdata, input rd_idx,
		output rdata);
endinterface

// *** shared/twbme_line_if.sv ***
`timescale 1ns/100ps
interface twbme_line_if;
	logic scl;
	logic sda;
	logic scl_rise;
	logic scl_fall;
	logic start_seen;
	logic stop_seen;
	modport sync (output scl, output sda, output scl_rise, output scl_fall,
		output start_seen, output stop_seen);
	modport engine (input scl, input sda, input scl_rise, input scl_fall,
		input start_seen, input stop_seen);
endinterface

// *** src/twbme_line_sync.sv ***
`timescale 1ns/100ps
module twbme_line_sync (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Raw bus pins
	input wire logic scl_i,
	input wire logic sda_i,
	// Conditioned lines
	twbme_line_if.sync line
);
	logic scl_m, scl_s, scl_d;
	logic sda_m, sda_s, sda_d;

	// Two stages, then one more for edge finding
	always_ff @(posedge clk) begin
		if (rst) begin
			scl_m <= 1'b1;
			scl_s <= 1'b1;
			scl_d <= 1'b1;
			sda_m <= 1'b1;
			sda_s <= 1'b1;
			sda_d <= 1'b1;
		end else begin
			scl_m <= scl_i;
			scl_s <= scl_m;
			scl_d <= scl_s;
			sda_m <= sda_i;
			sda_s <= sda_m;
			sda_d <= sda_s;
		end
	end

	// SDA moving while SCL stays high marks START or STOP
	assign line.scl = scl_s;
	assign line.sda = sda_s;
	assign line.scl_rise = scl_s & ~scl_d;
	assign line.scl_fall = ~scl_s & scl_d;
	assign line.start_seen = scl_s & scl_d & sda_d & ~sda_s;
	assign line.stop_seen = scl_s & scl_d & ~sda_d & sda_s;
endmodule // twbme_line_sync

// *** src/twbme_ahb_slave.sv ***
`timescale 1ns/100ps
module twbme_ahb_slave (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// Register side
	twbme_reg_if.bus rif
);
	logic wr_pend, next_wr_pend;
	logic rd_wait, next_rd_wait;
	logic [2:0] idx, next_idx;
	logic [31:0] next_hrdata;
	logic next_hreadyout;
	logic take;

	// Only word transfers exist, so hsize is not decoded
	assign take = hsel & hready & htrans[1];
	assign rif.wr = wr_pend;
	assign rif.wr_idx = idx;
	assign rif.wdata = hwdata[7:0];
	assign rif.rd_idx = idx;

	// One wait state on reads so a write just before is seen
	always_comb begin
		next_wr_pend = 1'b0;
		next_rd_wait = 1'b0;
		next_idx = idx;
		next_hrdata = hrdata;
		next_hreadyout = 1'b1;
		if (rd_wait) begin
			next_hrdata = {24'h000000, rif.rdata};
		end else if (take) begin
			next_idx = haddr[twbme_pkg::IDX_MSB:twbme_pkg::IDX_LSB];
			next_wr_pend = hwrite;
			next_rd_wait = ~hwrite;
			next_hreadyout = hwrite;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			wr_pend <= 1'b0;
			rd_wait <= 1'b0;
			idx <= 3'h0;
			hrdata <= 32'h00000000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			wr_pend <= next_wr_pend;
			rd_wait <= next_rd_wait;
			idx <= next_idx;
			hrdata <= next_hrdata;
			hreadyout <= next_hreadyout;
			hresp <= 1'b0;
		end
	end
endmodule // twbme_ahb_slave

// *** tb/twbme_chk_sva.sv ***
`timescale 1ns/100ps
module twbme_chk (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Register bus
	input wire logic hsel,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic [31:0] hrdata,
	// Bus pins and sleep
	input wire logic scl_i,
	input wire logic scl_o,
	input wire logic sda_o,
	input wire logic sda_oe_n,
	input wire logic clocks_stopped,
	input wire logic wake_request
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// A read costs exactly one wait cycle
	property p_rd_wait;
		hsel && hready && htrans[1] && !hwrite |=> !hreadyout ##1 hreadyout;
	endproperty
	a_rd_wait: assert property (p_rd_wait) else $error("read wait wrong");
	property p_wr_go;
		hsel && hready && htrans[1] && hwrite |=> hreadyout;
	endproperty
	a_wr_go: assert property (p_wr_go) else $error("write stalled");
	property p_okay;
		!hresp;
	endproperty
	a_okay: assert property (p_okay) else $error("error response");
	property p_hi0;
		hrdata[31:8] == 24'h0;
	endproperty
	a_hi0: assert property (p_hi0) else $error("upper data set");
	// Open drain: only the enables may move
	property p_od;
		!scl_o && !sda_o;
	endproperty
	a_od: assert property (p_od) else $error("pin driven high");
	property p_wake_src;
		$rose(wake_request) |-> $past(clocks_stopped);
	endproperty
	a_wake_src: assert property (p_wake_src) else $error("wake awake");
	property p_wake_hold;
		wake_request && clocks_stopped |=> wake_request;
	endproperty
	a_wake_hold: assert property (p_wake_hold) else $error("wake lost");
	property p_wake_clr;
		!clocks_stopped [*2] |-> !wake_request;
	endproperty
	a_wake_clr: assert property (p_wake_clr) else $error("wake stuck");
	c_rd: cover property (!hreadyout);
	c_wake: cover property ($rose(wake_request));
	c_start: cover property ($fell(sda_oe_n) && scl_i);
endmodule // twbme_chk

bind twbme_top twbme_chk u_chk (.clk, .rst, .hsel, .htrans, .hwrite,
	.hready, .hreadyout, .hresp, .hrdata, .scl_i, .scl_o, .sda_o,
	.sda_oe_n, .clocks_stopped, .wake_request);

// *** tb/twbme_far_end.sv ***
`timescale 1ns/100ps
module twbme_far_end (
	// Bus levels
	input wire logic scl,
	input wire logic sda,
	// Pulls, low drags the line down
	output logic scl_d,
	output logic sda_d
);
	int bits = 0;
	logic [7:0] got;
	initial begin
		scl_d = 1;
		sda_d = 1;
	end
	// A START restarts the count; its own SCL fall is not a bit
	always @(negedge sda) if (scl && scl_d) bits = -1;
	// Shift in while acting as slave
	always @(posedge scl) if (scl_d && bits < 8) got = {got[6:0], sda};
	// Ack low after the eighth fall, freed at the ninth
	always @(negedge scl) if (scl_d) begin
		bits++;
		if (bits == 8) sda_d = 0;
		if (bits == 9) begin
			sda_d = 1;
			bits = 0;
		end
	end
	// Master side; SCL released late so the stretch is seen
	task automatic send(input logic [7:0] b, output logic ack);
		// Start off the clock edge so no synchroniser race
		#5 sda_d = 0;
		#80 scl_d = 0;
		for (int i = 7; i >= 0; i--) begin
			#40 sda_d = b[i];
			#40 scl_d = 1;
			#80 scl_d = 0;
		end
		#40 sda_d = 1;
		#40 scl_d = 1;
		wait (scl === 1'b1);
		#40 ack = sda;
		#40 scl_d = 0;
		#400 scl_d = 1;
	endtask
endmodule // twbme_far_end

// *** tb/two_wire_bus_mode_engine_tb.sv ***
`timescale 1ns/100ps
module two_wire_bus_mode_engine_tb;
	logic clk, rst, hsel, hwrite, clocks_stopped, ack;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [7:0] q;
	logic hreadyout, hresp, scl_o, scl_oe_n, sda_o, sda_oe_n, wake_request;
	wire logic scl, sda, p_scl, p_sda;
	int n_fail = 0, checks_done = 0, cyc = 0;
	typedef struct {logic w; logic [7:0] a; logic [7:0] d;} twbme_row_t;
	// Reads compare d; collision shows in control bit 3
	twbme_row_t rows [11] = '{'{0, 8'h04, 8'hf8}, '{0, 8'h08, 8'hfe},
		'{0, 8'h0c, 8'hff}, '{0, 8'h10, 8'h00}, '{0, 8'h14, 8'h00},
		'{1, 8'h08, 8'h42}, '{0, 8'h08, 8'h42}, '{1, 8'h10, 8'h44},
		'{1, 8'h0c, 8'h5a}, '{0, 8'h10, 8'h4c}, '{0, 8'h0c, 8'hff}};
	initial begin
		clk = 0;
		forever #10 clk = ~clk;
	end
	// Wired-AND with pull-ups
	assign scl = scl_oe_n & p_scl;
	assign sda = sda_oe_n & p_sda;
	twbme_top #(.HALF_CYCLES(4)) uut (.clk(clk), .rst(rst), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hresp(hresp), .hrdata(hrdata), .scl_i(scl), .scl_o(scl_o),
		.scl_oe_n(scl_oe_n), .sda_i(sda), .sda_o(sda_o),
		.sda_oe_n(sda_oe_n), .clocks_stopped(clocks_stopped),
		.wake_request(wake_request));
	twbme_far_end far (.scl(scl), .sda(sda), .scl_d(p_scl), .sda_d(p_sda));
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		checks_done++;
		if (g !== e) begin
			n_fail++;
			$display("[FAIL] %0t got %h want %h", $time, g, e);
		end
	endtask
	// One AHB single transfer, held until hready
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [7:0] d);
		@(posedge clk);
		hsel <= 1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		do @(posedge clk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= {24'h0, d};
		do @(posedge clk); while (hreadyout !== 1'b1);
		q = hrdata[7:0];
	endtask
	task automatic wait_flag;
		do bus(0, 8'h10, 8'h0); while (q[7] !== 1'b1);
	endtask
	task automatic final_report;
		if (n_fail == 0 && checks_done > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// Watchdog against a hung handshake
	always @(posedge clk) begin
		cyc++;
		if (cyc == 30000) begin
			n_fail++;
			final_report;
		end
	end
	initial begin
		rst = 1;
		hsel = 0;
		htrans = 0;
		haddr = 0;
		hwrite = 0;
		hwdata = 0;
		hsize = 3'h2;
		clocks_stopped = 0;
		repeat (20) @(posedge clk);
		rst <= 0;
		foreach (rows[i]) begin
			bus(rows[i].w, rows[i].a, rows[i].d);
			if (!rows[i].w) chk(q, rows[i].d);
		end
		// Master: START, address with write, repeated START, STOP
		bus(1, 8'h10, 8'h24);
		wait_flag;
		bus(0, 8'h04, 0);
		chk(q, 8'h08);
		bus(1, 8'h0c, 8'ha0);
		bus(1, 8'h10, 8'h84);
		wait_flag;
		chk(q & 8'h08, 8'h00);
		bus(0, 8'h04, 0);
		chk(q, 8'h18);
		chk(far.got, 8'ha0);
		bus(1, 8'h10, 8'ha4);
		wait_flag;
		bus(0, 8'h04, 0);
		chk(q, 8'h10);
		bus(1, 8'h10, 8'h94);
		do bus(0, 8'h10, 0); while (q[4] !== 1'b0);
		bus(0, 8'h04, 0);
		chk(q, 8'hf8);
		// Sleeping slave addressed by the far master
		bus(1, 8'h10, 8'h44);
		clocks_stopped <= 1;
		@(posedge clk);
		far.send(8'h42, ack);
		repeat (4) @(posedge clk);
		chk({6'h0, ack, wake_request}, 8'h01);
		chk({7'h0, scl}, 8'h00);
		bus(0, 8'h04, 0);
		chk(q, 8'h60);
		bus(0, 8'h0c, 0);
		chk(q, 8'ha0);
		clocks_stopped <= 0;
		bus(1, 8'h10, 8'hd4);
		repeat (4) @(posedge clk);
		chk({6'h0, scl, wake_request}, 8'h02);
		bus(0, 8'h04, 0);
		chk(q, 8'hf8);
		// Second reset in mid-run restores the own address
		rst <= 1;
		repeat (2) @(posedge clk);
		rst <= 0;
		bus(0, 8'h08, 0);
		chk(q, 8'hfe);
		final_report;
	end
endmodule // two_wire_bus_mode_engine_tb
